// >>> logic/ccd_core.v
`timescale 1ns/100ps
// Functional notes
// RL1: clear register, zero flag set, one cycle
// RL2: complement register, zero flag from result
// RL3: destination bit picks accumulator or register
// RL4: watchdog clear, prescaler clear, set status bits
// RL5: compare reg minus acc, only zero carry
// RL6: decimal adjust accumulator, only carry changes
// RL7: software adjusts right after add, interrupts off
// RL8: decrement stored before zero test
// RL9: zero result discards prefetch, two cycles
// RL10: compare carry set when no borrow
// RL11: zero flag set when result is zero
`include "ccd_consts.vh"
module ccd_core (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_op_valid,
    input wire [2:0] i_op_code,
    input wire [5:0] i_op_addr,
    input wire i_op_dest,
    input wire i_presc_to_wdt,
    input wire [6:0] i_addr,
    input wire [7:0] i_wr_data,
    input wire i_wr,
    input wire i_rd,
    output wire [7:0] o_rd_data,
    output reg o_ready,
    output reg o_done,
    output reg o_skip,
    output reg o_wdt_clear,
    output reg o_presc_clear,
    output reg [7:0] o_acc,
    output reg o_zero,
    output reg o_carry
);
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [2:0] op_ff;
    reg [5:0] addr_ff;
    reg dest_ff;
    reg [7:0] acc_ff;
    reg [4:0] status_ff;
    reg [7:0] nxt_acc;
    reg [4:0] nxt_status;
    reg mem_we;
    reg [7:0] mem_wdata;
    reg [5:0] mem_waddr;
    reg core_we;
    reg [7:0] core_wdata;
    reg do_skip;
    reg [7:0] rd_reg_ff;
    reg rd_mem_ff;
    wire [7:0] reg_q;
    wire [7:0] bus_q;
    wire [8:0] cmp_diff;
    wire [7:0] dsz_res;
    wire [8:0] daa_lo;
    wire [8:0] daa_res;
    wire daa_hi_need;

    function is_zero;
        input [7:0] v;
        begin
            is_zero = (v == 8'h00); // RL11
        end
    endfunction

    assign cmp_diff = {1'b0, reg_q} - {1'b0, acc_ff}; // RL5
    assign dsz_res = reg_q - 8'h01; // RL8
    // low digit correction first; its carry may push the high digit over
    assign daa_lo = ((acc_ff[3:0] > `CCD_NIB_MAX) ||
                     status_ff[`CCD_ST_DIGIT]) ?
                    ({1'b0, acc_ff} + {1'b0, `CCD_ADJ_LO}) :
                    {1'b0, acc_ff};
    assign daa_hi_need = status_ff[`CCD_ST_CARRY] ||
                         (acc_ff > `CCD_HI_MAX);
    assign daa_res = daa_hi_need ?
                     ({1'b0, daa_lo[7:0]} + {1'b0, `CCD_ADJ_HI}) :
                     daa_lo; // RL6

    always @* begin
        nxt_state = state_ff;
        nxt_acc = acc_ff;
        nxt_status = status_ff;
        core_we = 1'b0;
        core_wdata = 8'h00;
        do_skip = 1'b0;
        case (state_ff)
            `CCD_S_IDLE: begin
                // ready stays low for one cycle after reset; refuse there
                if (i_op_valid && o_ready) begin
                    nxt_state = `CCD_S_EXEC;
                end
            end
            `CCD_S_EXEC: begin
                nxt_state = `CCD_S_IDLE;
                case (op_ff)
                    `CCD_OP_CLR: begin
                        core_we = 1'b1; // RL1
                        core_wdata = 8'h00;
                        nxt_status[`CCD_ST_ZERO] = 1'b1;
                    end
                    `CCD_OP_COM: begin
                        nxt_status[`CCD_ST_ZERO] = is_zero(~reg_q); // RL2
                        if (dest_ff == `CCD_DEST_REG) begin
                            core_we = 1'b1; // RL3
                            core_wdata = ~reg_q;
                        end else begin
                            nxt_acc = ~reg_q;
                        end
                    end
                    `CCD_OP_WDT: begin
                        nxt_status[`CCD_ST_TO] = 1'b1; // RL4
                        nxt_status[`CCD_ST_PD] = 1'b1;
                    end
                    `CCD_OP_CMP: begin
                        nxt_status[`CCD_ST_ZERO] = is_zero(cmp_diff[7:0]);
                        nxt_status[`CCD_ST_CARRY] = ~cmp_diff[8]; // RL10
                    end
                    `CCD_OP_DAA: begin
                        nxt_acc = daa_res[7:0];
                        nxt_status[`CCD_ST_CARRY] = daa_res[8] |
                                                    daa_hi_need;
                    end
                    `CCD_OP_DSZ: begin
                        if (dest_ff == `CCD_DEST_REG) begin
                            core_we = 1'b1; // RL3
                            core_wdata = dsz_res;
                        end else begin
                            nxt_acc = dsz_res;
                        end
                        if (is_zero(dsz_res)) begin
                            do_skip = 1'b1; // RL9
                            nxt_state = `CCD_S_SKIP;
                        end
                    end
                    default: begin
                        nxt_state = `CCD_S_IDLE;
                    end
                endcase
            end
            `CCD_S_SKIP: begin
                nxt_state = `CCD_S_IDLE;
            end
            default: begin
                nxt_state = `CCD_S_IDLE;
            end
        endcase
    end

    // the core's own write wins; a bus write in that cycle is dropped
    always @* begin
        mem_we = core_we;
        mem_waddr = addr_ff;
        mem_wdata = core_wdata;
        if (!core_we && i_wr && !i_addr[6]) begin
            mem_we = 1'b1;
            mem_waddr = i_addr[5:0];
            mem_wdata = i_wr_data;
        end
    end

    ccd_fmem u_fmem (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_ra_addr(i_op_addr),
        .o_ra_data(reg_q),
        .i_rb_addr(i_addr[5:0]),
        .o_rb_data(bus_q)
    );

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_ff <= `CCD_S_IDLE;
            op_ff <= `CCD_OP_CLR;
            addr_ff <= 6'h00;
            dest_ff <= 1'b0;
            acc_ff <= `CCD_ACC_RST;
            status_ff <= `CCD_STATUS_RST;
            o_ready <= 1'b0;
            o_done <= 1'b0;
            o_skip <= 1'b0;
            o_wdt_clear <= 1'b0;
            o_presc_clear <= 1'b0;
            o_acc <= `CCD_ACC_RST;
            o_zero <= 1'b0;
            o_carry <= 1'b0;
            rd_reg_ff <= 8'h00;
            rd_mem_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == `CCD_S_IDLE && i_op_valid && o_ready) begin
                op_ff <= i_op_code;
                addr_ff <= i_op_addr;
                dest_ff <= i_op_dest;
            end
            // software writes first; in an EXEC cycle the core rewrites acc_ff and
            // status_ff from its own result, so a software write in that cycle is lost
            if (i_wr && i_addr == `CCD_ADDR_ACC) begin
                acc_ff <= i_wr_data;
            end
            if (i_wr && i_addr == `CCD_ADDR_STATUS) begin
                status_ff <= i_wr_data[4:0];
            end
            if (state_ff == `CCD_S_EXEC) begin
                acc_ff <= nxt_acc;
                status_ff <= nxt_status;
            end
            o_ready <= (nxt_state == `CCD_S_IDLE);
            o_done <= (state_ff == `CCD_S_EXEC && !do_skip) ||
                      (state_ff == `CCD_S_SKIP); // RL9
            o_skip <= do_skip; // RL9
            o_wdt_clear <= (state_ff == `CCD_S_EXEC) &&
                           (op_ff == `CCD_OP_WDT); // RL4
            o_presc_clear <= (state_ff == `CCD_S_EXEC) &&
                             (op_ff == `CCD_OP_WDT) &&
                             i_presc_to_wdt; // RL4
            o_acc <= (state_ff == `CCD_S_EXEC) ? nxt_acc :
                     ((i_wr && i_addr == `CCD_ADDR_ACC) ?
                      i_wr_data : acc_ff);
            o_zero <= (state_ff == `CCD_S_EXEC) ?
                      nxt_status[`CCD_ST_ZERO] :
                      ((i_wr && i_addr == `CCD_ADDR_STATUS) ?
                       i_wr_data[`CCD_ST_ZERO] : status_ff[`CCD_ST_ZERO]);
            o_carry <= (state_ff == `CCD_S_EXEC) ?
                       nxt_status[`CCD_ST_CARRY] :
                       ((i_wr && i_addr == `CCD_ADDR_STATUS) ?
                        i_wr_data[`CCD_ST_CARRY] :
                        status_ff[`CCD_ST_CARRY]);
            rd_mem_ff <= i_rd && !i_addr[6];
            if (i_rd && i_addr == `CCD_ADDR_ACC) begin
                rd_reg_ff <= acc_ff;
            end else if (i_rd && i_addr == `CCD_ADDR_STATUS) begin
                rd_reg_ff <= {3'h0, status_ff};
            end else begin
                rd_reg_ff <= 8'h00;
            end
        end
    end

    // both legs are registers; the select avoids a second cycle of latency
    assign o_rd_data = rd_mem_ff ? bus_q : rd_reg_ff;
endmodule

// >>> logic/ccd_consts.vh
`ifndef CCD_CONSTS_VH
`define CCD_CONSTS_VH
// operation codes on the instruction port
`define CCD_OP_CLR 3'h0
`define CCD_OP_COM 3'h1
`define CCD_OP_WDT 3'h2
`define CCD_OP_CMP 3'h3
`define CCD_OP_DAA 3'h4
`define CCD_OP_DSZ 3'h5
// destination select
`define CCD_DEST_ACC 1'b0
`define CCD_DEST_REG 1'b1
// bus map: 0x00..0x3F file registers
`define CCD_ADDR_ACC 7'h40
`define CCD_ADDR_STATUS 7'h41
// status field positions
`define CCD_ST_CARRY 0
`define CCD_ST_DIGIT 1
`define CCD_ST_ZERO 2
`define CCD_ST_PD 3
`define CCD_ST_TO 4
// reset values
`define CCD_ACC_RST 8'h00
`define CCD_STATUS_RST 5'h18
// decimal adjust
`define CCD_NIB_MAX 4'h9
`define CCD_ADJ_LO 8'h06
`define CCD_ADJ_HI 8'h60
`define CCD_HI_MAX 8'h99
// execution states
`define CCD_S_IDLE 2'h0
`define CCD_S_EXEC 2'h1
`define CCD_S_SKIP 2'h2
`endif

// >>> logic/ccd_fmem.v
`timescale 1ns/100ps
// 64 x 8 file register array, one write port, two registered read ports
module ccd_fmem (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_we,
    input wire [5:0] i_waddr,
    input wire [7:0] i_wdata,
    input wire [5:0] i_ra_addr,
    output reg [7:0] o_ra_data,
    input wire [5:0] i_rb_addr,
    output reg [7:0] o_rb_data
);
    reg [7:0] mem [0:63];

    always @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // read ports see the old word during a write to the same address
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_ra_data <= 8'h00;
            o_rb_data <= 8'h00;
        end else begin
            o_ra_data <= mem[i_ra_addr];
            o_rb_data <= mem[i_rb_addr];
        end
    end
endmodule

// >>> test/ccd_core_monitor.sv
`timescale 1ns/100ps
`include "ccd_consts.vh"
module ccd_core_monitor (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_op_valid,
    input wire [2:0] i_op_code,
    input wire i_op_dest,
    input wire i_presc_to_wdt,
    input wire o_ready,
    input wire o_done,
    input wire o_skip,
    input wire o_wdt_clear,
    input wire o_presc_clear,
    input wire [7:0] o_acc,
    input wire o_zero
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    wire take = o_ready && i_op_valid;
    property p_clr;
        take && i_op_code == `CCD_OP_CLR |-> ##2 o_done && o_zero;
    endproperty
    a_clr: assert property (p_clr)
        else $error("clear op flag or timing");
    property p_com;
        take && i_op_code == `CCD_OP_COM && !i_op_dest
            |-> ##2 o_zero == (o_acc == 8'h00);
    endproperty
    a_com: assert property (p_com)
        else $error("complement zero flag");
    property p_wdt;
        take && i_op_code == `CCD_OP_WDT
            |-> ##2 o_wdt_clear && o_presc_clear == $past(i_presc_to_wdt);
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog clear pulses");
    property p_prs;
        o_presc_clear |-> o_wdt_clear;
    endproperty
    a_prs: assert property (p_prs)
        else $error("prescaler clear alone");
    property p_cmp;
        take && i_op_code == `CCD_OP_CMP |=> ##1 o_done && $stable(o_acc);
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("compare changed accumulator");
    property p_daa;
        take && i_op_code == `CCD_OP_DAA |=> ##1 o_done && $stable(o_zero);
    endproperty
    a_daa: assert property (p_daa)
        else $error("decimal adjust touched zero");
    property p_dsz;
        take && i_op_code == `CCD_OP_DSZ && !i_op_dest
            |=> ##1 o_skip == (o_acc == 8'h00);
    endproperty
    a_dsz: assert property (p_dsz)
        else $error("skip not from stored result");
    property p_skp;
        o_skip |-> !o_ready && !o_done ##1 o_done;
    endproperty
    a_skp: assert property (p_skp)
        else $error("skip cycle wrong");
endmodule
bind ccd_core ccd_core_monitor u_mon (.*);

// >>> test/tb.sv
`timescale 1ns/100ps
`include "ccd_consts.vh"
module tb;
    logic i_ref_clk, i_sys_rst, i_op_valid, i_op_dest, i_presc_to_wdt;
    logic i_wr, i_rd;
    logic [2:0] i_op_code;
    logic [5:0] i_op_addr;
    logic [6:0] i_addr;
    logic [7:0] i_wr_data;
    wire [7:0] o_rd_data, o_acc;
    wire o_ready, o_done, o_skip, o_wdt_clear, o_presc_clear;
    wire o_zero, o_carry;
    int n_mismatch = 0;
    int check_count = 0;
    logic [7:0] av[3] = '{8'h12, 8'h35, 8'h34};
    logic [7:0] di[2] = '{8'h4D, 8'hA5};
    logic [7:0] dq[2] = '{8'h53, 8'h05};
    ccd_core DUT (.*);
    initial begin
        i_ref_clk = 0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    task chk(input string nm, input [7:0] s, input [7:0] e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    task stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task wr(input [6:0] a, input [7:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_ref_clk);
        i_wr <= 0;
    endtask
    task rd(input [6:0] a, input [7:0] e);
        @(posedge i_ref_clk);
        i_rd <= 1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 0;
        #1 chk("rd", o_rd_data, e);
    endtask
    // waits out a busy core, then counts cycles from take to done
    task op(input [2:0] c, input [5:0] a, input d, input p,
            input [7:0] nc);
        logic [7:0] n;
        logic sk;
        // the take cycle counts as the first cycle of the op
        n = 1;
        sk = 0;
        @(posedge i_ref_clk);
        while (o_ready !== 1'b1) @(posedge i_ref_clk);
        i_op_valid <= 1;
        i_op_code <= c;
        i_op_addr <= a;
        i_op_dest <= d;
        i_presc_to_wdt <= p;
        @(posedge i_ref_clk);
        i_op_valid <= 0;
        while (o_done !== 1'b1 && n < 6) begin
            @(posedge i_ref_clk);
            #1;
            n++;
            sk = sk | o_skip;
        end
        chk("cycles", n, nc);
        chk("skip", sk, nc == 3);
    endtask
    initial begin
        {i_op_valid, i_op_code, i_op_addr, i_op_dest} = 0;
        {i_presc_to_wdt, i_addr, i_wr_data, i_wr, i_rd} = 0;
        i_sys_rst = 1;
        repeat (10) @(posedge i_ref_clk);
        i_sys_rst <= 0;
        rd(`CCD_ADDR_STATUS, 8'h18);
        rd(`CCD_ADDR_ACC, 8'h00);
        wr(7'h05, 8'h55);
        op(`CCD_OP_CLR, 6'h05, 0, 0, 2);
        chk("zero", o_zero, 1);
        rd(7'h05, 8'h00);
        wr(7'h06, 8'hA6);
        op(`CCD_OP_COM, 6'h06, 1, 0, 2);
        chk("zero", o_zero, 0);
        rd(7'h06, 8'h59);
        wr(7'h3F, 8'hFF);
        op(`CCD_OP_COM, 6'h3F, 0, 0, 2);
        chk("acc", o_acc, 8'h00);
        chk("zero", o_zero, 1);
        rd(7'h3F, 8'hFF);
        wr(`CCD_ADDR_STATUS, 8'h00);
        op(`CCD_OP_WDT, 0, 0, 1, 2);
        rd(`CCD_ADDR_STATUS, 8'h18);
        op(`CCD_OP_WDT, 0, 0, 0, 2);
        wr(7'h08, 8'h34);
        for (int i = 0; i < 3; i++) begin
            wr(`CCD_ADDR_ACC, av[i]);
            op(`CCD_OP_CMP, 6'h08, 0, 0, 2);
            chk("carry", o_carry, i != 1);
            chk("zero", o_zero, i == 2);
            chk("acc", o_acc, av[i]);
            rd(7'h08, 8'h34);
        end
        for (int i = 0; i < 2; i++) begin
            wr(`CCD_ADDR_STATUS, 8'h18);
            wr(`CCD_ADDR_ACC, di[i]);
            op(`CCD_OP_DAA, 0, 0, 0, 2);
            chk("acc", o_acc, dq[i]);
            chk("carry", o_carry, i);
        end
        wr(7'h09, 8'h01);
        op(`CCD_OP_DSZ, 6'h09, 1, 0, 3);
        rd(7'h09, 8'h00);
        wr(7'h0A, 8'h03);
        op(`CCD_OP_DSZ, 6'h0A, 0, 0, 2);
        chk("acc", o_acc, 8'h02);
        rd(7'h0A, 8'h03);
        wr(7'h0B, 8'h01);
        op(`CCD_OP_DSZ, 6'h0B, 0, 0, 3);
        chk("acc", o_acc, 8'h00);
        // unmapped space reads zero and drops writes
        wr(7'h10, 8'h00);
        wr(7'h50, 8'hAA);
        rd(7'h50, 8'h00);
        rd(7'h10, 8'h00);
        chk("acc", o_acc, 8'h00);
        stop_test;
    end
    initial begin
        #(40 * 4000);
        n_mismatch++;
        stop_test;
    end
endmodule
